//--- rtc_alarm_registers_tb_top.sv
// self-checking bench for the alarm register set
`timescale 1ns/1ns
`include "rtcal_params.svh"
module rtc_alarm_registers_tb_top
   import rtcal_pkg::*;
   ;
   logic        sys_clk, reset, wr_en, rd_pend, m_pend, wk_match, dy_match;
   logic        rd_p1 = 1'b0;
   logic        m_p1 = 1'b0;
   rtcal_addr_t wr_addr, rd_addr;
   rtcal_byte_t wr_data, rd_data, cur_min, cur_hour, d;
   rtcal_wday_t cur_wday;
   int          bad_count = 0;
   int          comparisons = 0;
   integer      seed = 32'h30ae;
   rtcal_addr_t ad [5] = '{`RTCAL_ADDR_WK_MIN, `RTCAL_ADDR_WK_HOUR, `RTCAL_ADDR_WK_DAYS,
                           `RTCAL_ADDR_DY_MIN, `RTCAL_ADDR_DY_HOUR};
   rtcal_byte_t mk [5] = '{`RTCAL_MIN_MASK, `RTCAL_HOUR_MASK, `RTCAL_DAYS_MASK,
                           `RTCAL_MIN_MASK, `RTCAL_HOUR_MASK};

   rtcal_host i_rtcal_host (.sys_clk_in(sys_clk), .wr_en_out(wr_en), .wr_addr_out(wr_addr),
      .wr_data_out(wr_data), .rd_addr_out(rd_addr), .cur_min_out(cur_min),
      .cur_hour_out(cur_hour), .cur_wday_out(cur_wday), .rd_pend_out(rd_pend),
      .m_pend_out(m_pend));
   rtcal_alarm i_rtcal_alarm (.sys_clk_in(sys_clk), .reset_in(reset), .wr_en_in(wr_en),
      .wr_addr_in(wr_addr), .wr_data_in(wr_data), .rd_addr_in(rd_addr),
      .rd_data_out(rd_data), .cur_min_in(cur_min), .cur_hour_in(cur_hour),
      .cur_wday_in(cur_wday), .weekly_match_out(wk_match), .daily_match_out(dy_match));

   task automatic cmp_byte(input rtcal_byte_t got, input rtcal_byte_t exp);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cmp_match(input logic [1:0] got, input logic [1:0] exp);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic print_verdict();
      if (bad_count == 0 && comparisons > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end
   // result watcher: oldest note against settled outputs
   always @(posedge sys_clk) begin
      rd_p1 <= rd_pend;
      m_p1  <= m_pend;
      if (rd_p1) cmp_byte(rd_data, i_rtcal_host.rd_q.pop_front());
      if (m_p1) cmp_match({wk_match, dy_match}, i_rtcal_host.m_q.pop_front());
   end
   initial begin
      repeat (5000) @(posedge sys_clk);
      bad_count++;
      print_verdict();
   end
   // ---------------------------------------------
   // main sequence
   // ---------------------------------------------
   initial begin
      reset = 1'b1;
      repeat (2) @(posedge sys_clk);
      reset <= 1'b0;
      for (int a = 8; a < 14; a++) i_rtcal_host.rd(a[3:0], 8'h00);
      for (int i = 0; i < 15; i++) begin
         d = 8'($random(seed));
         i_rtcal_host.wr(ad[i % 5], d);
         i_rtcal_host.rd(ad[i % 5], d & mk[i % 5]);
      end
      // unmapped write dropped
      i_rtcal_host.wr(4'h3, 8'hFF);
      i_rtcal_host.rd(4'h3, 8'h00);
      i_rtcal_host.wr(`RTCAL_ADDR_DY_MIN, 8'h30);
      i_rtcal_host.wr(`RTCAL_ADDR_DY_HOUR, 8'h32);
      i_rtcal_host.wr(`RTCAL_ADDR_WK_MIN, 8'h59);
      i_rtcal_host.wr(`RTCAL_ADDR_WK_HOUR, 8'h23);
      i_rtcal_host.tm(8'h30, 8'h32, 3'h0, 2'b01);
      i_rtcal_host.tm(8'h30, 8'h12, 3'h0, 2'b00);
      i_rtcal_host.tm(8'h31, 8'h32, 3'h0, 2'b00);
      i_rtcal_host.tm(8'h59, 8'h03, 3'h0, 2'b00);
      for (int n = 0; n < 8; n++) begin
         i_rtcal_host.wr(`RTCAL_ADDR_WK_DAYS, (n < 7) ? 8'h01 << n : 8'h00);
         // code seven only while no day is enabled
         for (int w = 0; w < ((n < 7) ? 7 : 8); w++) begin
            i_rtcal_host.tm(8'h59, 8'h23, w[2:0], {n == w && w < 7, 1'b0});
         end
      end
      repeat (4) @(posedge sys_clk);
      print_verdict();
   end
endmodule // rtc_alarm_registers_tb_top

//--- rtcal_alarm.sv
// alarm registers and alarm match logic
// Function
// - weekday mask register at Ah, seven enables, top bit reads zero.
// - enable bit n matches day-of-week code n, codes 0 to 6.
// - all enables clear means weekly alarm never fires.
// - weekly hour bit 5 is pm flag or twenty-hours bit.
// - daily minute register at Bh, BCD minutes, top bit zero.
// - daily hour register at Ch, BCD hours, top two bits zero.
// - daily hour bit 5 is pm flag or twenty-hours bit.
// - twelve-hour midnight is 12, noon is 32.
// - after power-on values are unspecified, reserved bits read zero.
// - an impossible alarm time simply never matches.
// - weekly minute at 8h and hour at 9h registers.
`timescale 1ns/1ns
`include "rtcal_params.svh"
module rtcal_alarm
   import rtcal_pkg::*;
(
   // clock and reset
   input  wire logic        sys_clk_in,
   input  wire logic        reset_in,
   // register access
   input  wire logic        wr_en_in,
   input  wire rtcal_addr_t wr_addr_in,
   input  wire rtcal_byte_t wr_data_in,
   input  wire rtcal_addr_t rd_addr_in,
   output rtcal_byte_t      rd_data_out,
   // current time in the same coding as the alarm registers
   input  wire rtcal_byte_t cur_min_in,
   input  wire rtcal_byte_t cur_hour_in,
   input  wire rtcal_wday_t cur_wday_in,
   // match outputs
   output logic             weekly_match_out,
   output logic             daily_match_out
);
   rtcal_byte_t wk_min, wk_hour, wk_days, dy_min, dy_hour;
   logic        weekly_match, daily_match;
   logic        next_weekly_match, next_daily_match;
   logic        day_enabled;

   // ------------------------------------------------------------
   // register storage
   // ------------------------------------------------------------
   rtcal_regs i_rtcal_regs (
      .sys_clk_in  (sys_clk_in),
      .reset_in    (reset_in),
      .wr_en_in    (wr_en_in),
      .wr_addr_in  (wr_addr_in),
      .wr_data_in  (wr_data_in),
      .rd_addr_in  (rd_addr_in),
      .rd_data_out (rd_data_out),
      .wk_min_out  (wk_min),
      .wk_hour_out (wk_hour),
      .wk_days_out (wk_days),
      .dy_min_out  (dy_min),
      .dy_hour_out (dy_hour)
   );

   // ------------------------------------------------------------
   // match logic
   // ------------------------------------------------------------
   // compare a stored field against the current value under its mask
   function automatic logic field_eq(input rtcal_byte_t a, input rtcal_byte_t b,
                                     input rtcal_byte_t m);
      field_eq = ((a ^ b) & m) == 8'h00;
   endfunction

   always_comb begin
      day_enabled = (cur_wday_in != 3'd7) && wk_days[cur_wday_in];
      next_weekly_match = day_enabled
                          && field_eq(wk_min,  cur_min_in,  `RTCAL_MIN_MASK)
                          && field_eq(wk_hour, cur_hour_in, `RTCAL_HOUR_MASK);
      next_daily_match  = field_eq(dy_min,  cur_min_in,  `RTCAL_MIN_MASK)
                          && field_eq(dy_hour, cur_hour_in, `RTCAL_HOUR_MASK);
   end

   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         weekly_match <= 1'b0;
         daily_match  <= 1'b0;
      end else begin
         weekly_match <= next_weekly_match;
         daily_match  <= next_daily_match;
      end
   end

   assign weekly_match_out = weekly_match;
   assign daily_match_out  = daily_match;

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   sequence s_wr_days;
      !reset_in && wr_en_in && wr_addr_in == `RTCAL_ADDR_WK_DAYS;
   endsequence

   sequence s_rd_days;
      rd_addr_in == `RTCAL_ADDR_WK_DAYS;
   endsequence

   sequence s_wr_wk_min;
      !reset_in && wr_en_in && wr_addr_in == `RTCAL_ADDR_WK_MIN;
   endsequence

   sequence s_rd_wk_min;
      !wr_en_in && rd_addr_in == `RTCAL_ADDR_WK_MIN;
   endsequence

   sequence s_wr_wk_hour;
      !reset_in && wr_en_in && wr_addr_in == `RTCAL_ADDR_WK_HOUR;
   endsequence

   sequence s_rd_wk_hour;
      !wr_en_in && rd_addr_in == `RTCAL_ADDR_WK_HOUR;
   endsequence

   sequence s_wr_dy_min;
      !reset_in && wr_en_in && wr_addr_in == `RTCAL_ADDR_DY_MIN;
   endsequence

   sequence s_rd_dy_min;
      !wr_en_in && rd_addr_in == `RTCAL_ADDR_DY_MIN;
   endsequence

   sequence s_wr_dy_hour;
      !reset_in && wr_en_in && wr_addr_in == `RTCAL_ADDR_DY_HOUR;
   endsequence

   sequence s_rd_dy_hour;
      !wr_en_in && rd_addr_in == `RTCAL_ADDR_DY_HOUR;
   endsequence

   a_days_top_zero: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      s_rd_days |=> rd_data_out[7] == 1'b0) else $error("day mask top bit not zero");

   a_days_write_back: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      s_wr_days ##1 (!wr_en_in and s_rd_days) |=> rd_data_out == ($past(wr_data_in, 2) & 8'h7F))
      else $error("day mask readback wrong");

   a_empty_mask_quiet: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      wk_days == 8'h00 |=> !weekly_match_out) else $error("weekly fired with empty mask");

   a_weekly_cause: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      weekly_match_out |-> $past(wk_days[cur_wday_in]) && $past(cur_wday_in) != 3'd7)
      else $error("weekly match without enabled day");

   a_weekly_hit: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      (cur_wday_in != 3'd7 && wk_days[cur_wday_in] && (cur_min_in & 8'h7F) == wk_min
       && (cur_hour_in & 8'h3F) == wk_hour && !reset_in) |=> weekly_match_out)
      else $error("weekly match missed");

   a_daily_hit: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      (!reset_in && (cur_min_in & 8'h7F) == dy_min && (cur_hour_in & 8'h3F) == dy_hour)
      |=> daily_match_out) else $error("daily match missed");

   a_daily_cause: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      daily_match_out |-> $past(cur_min_in[6:0]) == $past(dy_min[6:0]))
      else $error("daily match on wrong minute");

   a_min_top_zero: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      rd_addr_in == `RTCAL_ADDR_DY_MIN |=> rd_data_out[7] == 1'b0)
      else $error("minute top bit not zero");

   a_hour_top_zero: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      rd_addr_in == `RTCAL_ADDR_DY_HOUR |=> rd_data_out[7:6] == 2'b00)
      else $error("hour top bits not zero");

   a_wk_hour_top: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      rd_addr_in == `RTCAL_ADDR_WK_HOUR |=> rd_data_out[7:6] == 2'b00)
      else $error("weekly hour top bits not zero");

   a_wk_min_top: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      rd_addr_in == `RTCAL_ADDR_WK_MIN |=> rd_data_out[7] == 1'b0)
      else $error("weekly minute top bit not zero");

   a_wk_min_back: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      s_wr_wk_min ##1 s_rd_wk_min |=> rd_data_out == ($past(wr_data_in, 2) & `RTCAL_MIN_MASK))
      else $error("weekly minute readback wrong");

   a_wk_hour_back: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      s_wr_wk_hour ##1 s_rd_wk_hour |=> rd_data_out == ($past(wr_data_in, 2) & `RTCAL_HOUR_MASK))
      else $error("weekly hour readback wrong");

   a_dy_min_back: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      s_wr_dy_min ##1 s_rd_dy_min |=> rd_data_out == ($past(wr_data_in, 2) & `RTCAL_MIN_MASK))
      else $error("daily minute readback wrong");

   a_dy_hour_back: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      s_wr_dy_hour ##1 s_rd_dy_hour |=> rd_data_out == ($past(wr_data_in, 2) & `RTCAL_HOUR_MASK))
      else $error("daily hour readback wrong");

   a_days_hold: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      !reset_in && !wr_en_in |=> $stable(wk_days))
      else $error("day mask changed without a write");

   a_days_stored_top: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      wk_days[7] == 1'b0) else $error("day mask holds a top bit");

   // ------------------------------------------------------------
   // match assertions
   // ------------------------------------------------------------
   a_weekly_time: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      weekly_match_out |-> $past(cur_min_in[6:0]) == $past(wk_min[6:0])
      && $past(cur_hour_in[5:0]) == $past(wk_hour[5:0]))
      else $error("weekly match on wrong time");

   a_daily_hour_cause: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      daily_match_out |-> $past(cur_hour_in[5:0]) == $past(dy_hour[5:0]))
      else $error("daily match on wrong hour");

   a_code7_quiet: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      cur_wday_in == 3'd7 |=> !weekly_match_out) else $error("weekly match on day code seven");

   a_dy_pm_split: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      cur_hour_in[5] != dy_hour[5] |=> !daily_match_out)
      else $error("daily match ignored hour bit five");

   a_wk_pm_split: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      cur_hour_in[5] != wk_hour[5] |=> !weekly_match_out)
      else $error("weekly match ignored hour bit five");
endmodule // rtcal_alarm

//--- rtcal_host.sv
// host model: register access and current time source
`timescale 1ns/1ns
module rtcal_host
   import rtcal_pkg::*;
(
   // clock
   input  wire logic   sys_clk_in,
   // register access
   output logic        wr_en_out,
   output rtcal_addr_t wr_addr_out,
   output rtcal_byte_t wr_data_out,
   output rtcal_addr_t rd_addr_out,
   // current time and result strobes
   output rtcal_byte_t cur_min_out,
   output rtcal_byte_t cur_hour_out,
   output rtcal_wday_t cur_wday_out,
   output logic        rd_pend_out,
   output logic        m_pend_out
);
   rtcal_byte_t rd_q[$];
   logic [1:0]  m_q[$];
   initial begin
      {wr_en_out, wr_addr_out, wr_data_out, rd_addr_out} = '0;
      {cur_min_out, cur_hour_out, cur_wday_out, rd_pend_out, m_pend_out} = '0;
   end
   task automatic wr(input rtcal_addr_t a, input rtcal_byte_t d);
      @(posedge sys_clk_in);
      wr_en_out   <= 1'b1;
      wr_addr_out <= a;
      // read address follows the write so readback shows next cycle
      rd_addr_out <= a;
      wr_data_out <= d;
      @(posedge sys_clk_in);
      // released data shows inverse of last value
      wr_en_out   <= 1'b0;
      wr_data_out <= ~d;
   endtask
   task automatic rd(input rtcal_addr_t a, input rtcal_byte_t e);
      @(posedge sys_clk_in);
      rd_addr_out <= a;
      rd_pend_out <= 1'b1;
      rd_q.push_back(e);
      @(posedge sys_clk_in);
      rd_pend_out <= 1'b0;
   endtask
   task automatic tm(input rtcal_byte_t m, input rtcal_byte_t h, input rtcal_wday_t w,
                     input logic [1:0] e);
      @(posedge sys_clk_in);
      cur_min_out  <= m;
      cur_hour_out <= h;
      cur_wday_out <= w;
      m_pend_out   <= 1'b1;
      m_q.push_back(e);
      @(posedge sys_clk_in);
      m_pend_out   <= 1'b0;
   endtask
endmodule // rtcal_host

//--- rtcal_params.svh
// constants for the alarm register set
`ifndef RTCAL_PARAMS_SVH
`define RTCAL_PARAMS_SVH
`define RTCAL_ADDR_WK_MIN    4'h8
`define RTCAL_ADDR_WK_HOUR   4'h9
`define RTCAL_ADDR_WK_DAYS   4'hA
`define RTCAL_ADDR_DY_MIN    4'hB
`define RTCAL_ADDR_DY_HOUR   4'hC
`define RTCAL_MIN_MASK       8'h7F
`define RTCAL_HOUR_MASK      8'h3F
`define RTCAL_DAYS_MASK      8'h7F
`define RTCAL_PON_FILL       8'h00
`endif

//--- rtcal_pkg.sv
// types for the alarm register set
package rtcal_pkg;
   typedef logic [7:0] rtcal_byte_t;
   typedef logic [3:0] rtcal_addr_t;
   typedef logic [2:0] rtcal_wday_t;
endpackage

//--- rtcal_regs.sv
// alarm register storage with registered read data
`timescale 1ns/1ns
`include "rtcal_params.svh"
module rtcal_regs
   import rtcal_pkg::*;
(
   // clock and reset
   input  wire logic        sys_clk_in,
   input  wire logic        reset_in,
   // write port
   input  wire logic        wr_en_in,
   input  wire rtcal_addr_t wr_addr_in,
   input  wire rtcal_byte_t wr_data_in,
   // read port
   input  wire rtcal_addr_t rd_addr_in,
   output rtcal_byte_t      rd_data_out,
   // stored values
   output rtcal_byte_t      wk_min_out,
   output rtcal_byte_t      wk_hour_out,
   output rtcal_byte_t      wk_days_out,
   output rtcal_byte_t      dy_min_out,
   output rtcal_byte_t      dy_hour_out
);
   rtcal_byte_t wk_min, wk_hour, wk_days, dy_min, dy_hour, rd_data;
   rtcal_byte_t next_wk_min, next_wk_hour, next_wk_days, next_dy_min, next_dy_hour;
   rtcal_byte_t next_rd_data;

   always_comb begin
      next_wk_min  = wk_min;
      next_wk_hour = wk_hour;
      next_wk_days = wk_days;
      next_dy_min  = dy_min;
      next_dy_hour = dy_hour;
      if (wr_en_in) begin
         unique case (wr_addr_in)
            `RTCAL_ADDR_WK_MIN:  next_wk_min  = wr_data_in & `RTCAL_MIN_MASK;
            `RTCAL_ADDR_WK_HOUR: next_wk_hour = wr_data_in & `RTCAL_HOUR_MASK;
            `RTCAL_ADDR_WK_DAYS: next_wk_days = wr_data_in & `RTCAL_DAYS_MASK;
            `RTCAL_ADDR_DY_MIN:  next_dy_min  = wr_data_in & `RTCAL_MIN_MASK;
            `RTCAL_ADDR_DY_HOUR: next_dy_hour = wr_data_in & `RTCAL_HOUR_MASK;
            default: ;
         endcase
      end
      unique case (rd_addr_in)
         `RTCAL_ADDR_WK_MIN:  next_rd_data = wk_min;
         `RTCAL_ADDR_WK_HOUR: next_rd_data = wk_hour;
         `RTCAL_ADDR_WK_DAYS: next_rd_data = wk_days;
         `RTCAL_ADDR_DY_MIN:  next_rd_data = dy_min;
         `RTCAL_ADDR_DY_HOUR: next_rd_data = dy_hour;
         default:             next_rd_data = 8'h00;
      endcase
   end

   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         wk_min  <= `RTCAL_PON_FILL;
         wk_hour <= `RTCAL_PON_FILL;
         wk_days <= `RTCAL_PON_FILL;
         dy_min  <= `RTCAL_PON_FILL;
         dy_hour <= `RTCAL_PON_FILL;
         rd_data <= 8'h00;
      end else begin
         wk_min  <= next_wk_min;
         wk_hour <= next_wk_hour;
         wk_days <= next_wk_days;
         dy_min  <= next_dy_min;
         dy_hour <= next_dy_hour;
         rd_data <= next_rd_data;
      end
   end

   assign rd_data_out = rd_data;
   assign wk_min_out  = wk_min;
   assign wk_hour_out = wk_hour;
   assign wk_days_out = wk_days;
   assign dy_min_out  = dy_min;
   assign dy_hour_out = dy_hour;
endmodule // rtcal_regs
